// ### rtl/hiwc_pkg.sv
// Shared constants and types of the halt, idle and wake-up controller
package hiwc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WAKE_EN = 8'h08;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_WDT_COUNT = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_LO_KEEP = 0;
  localparam int CTRL_HI_KEEP = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int STAT_PDF = 0;
  localparam int STAT_TO = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int EVT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] WDT_SEL_RESET = 3'h3;
  localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog division exponents, indexed by the period select code
  localparam logic [4:0] WDT_EXP [8] = '{5'h08, 5'h0a, 5'h0c, 5'h0e,
                                         5'h0f, 5'h10, 5'h11, 5'h12};

  // Cycles the oscillator-stable path needs before its level is trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_IDLE_SLOW_ONLY = 2'b01,
    MODE_IDLE_FAST_ONLY = 2'b10,
    MODE_IDLE_BOTH_CLOCKS = 2'b11
  } hiwc_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALTED = 2'b01,
    ST_STABILISE = 2'b11,
    ST_RESUME = 2'b10
  } hiwc_state_t;

  typedef struct packed {
    logic [2:0] wdt_period_sel;
    logic hi_osc_keep_on_halt;
    logic lo_osc_keep_on_halt;
  } hiwc_ctrl_t;

  // Sticky events: bit order matches the interrupt status register
  typedef struct packed {
    logic wdt_run_reset;
    logic wake_wdt;
    logic wake_irq;
    logic wake_pin;
  } hiwc_evt_t;

endpackage : hiwc_pkg

// ### rtl/hiwc_sync_edge.sv
// Two-stage synchroniser with edge detection for asynchronous inputs
`timescale 1ns/1ps
module hiwc_sync_edge #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] fall_out,
  output logic [W-1:0] rise_out
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] last;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta <= '0;
      sync <= '0;
      last <= '0;
    end else begin
      meta <= async_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_out = sync;
  assign fall_out = last & ~sync;
  assign rise_out = ~last & sync;

endmodule : hiwc_sync_edge

// ### rtl/hiwc_top.sv
// Halt, idle and wake-up controller with watchdog, on an AHB-Lite slave
//
// Summary of operation
// R1: Halt with high keep 0, low keep 1: stop fast clock, keep slow clock.
// R2: Halt with both keep bits 1: both clocks run, execution halts.
// R3: Halt with high keep 1, low keep 0: fast clock on, slow clock off.
// R4: Memory, registers and ports hold their values while halted.
// R5: Halt sets the power-down flag and clears the watchdog-expiry flag; an overflow in the halt cycle sets it instead.
// R6: Halt clears the watchdog counter, which keeps counting afterwards.
// R7: Wake on enabled port A falling edge, interrupt, or watchdog overflow.
// R8: Power-down flag clears only on power-up or clear-watchdog.
// R9: Overflow while halted sets expiry flag, resets only PC and stack pointer.
// R10: Per-pin wake enables; pin wake resumes after the halt.
// R11: Disabled interrupt or full stack: resume after halt, request stays pending.
// R12: Enabled interrupt with free stack level: take the interrupt at once.
// R13: A request flag already set at halt cannot wake the device.
// R14: Resume only once the system oscillator has restarted and stabilised.
// R15: Watchdog counts ticks of the low-speed RC oscillator.
// R16: Watchdog ratio programmable from 2^8 to 2^18 by period select.
// R17: Halt with both keep bits 0: sleep, system clock stopped.
// R18: Period codes 0..7 give 2^8,10,12,14,15,16,17,18.
// R19: Pin and slow-clock events are synchronised before resuming.
`timescale 1ns/1ps
module hiwc_top #(
  parameter int PORT_W = 8,
  parameter int IRQ_W = 8,
  parameter int WDT_W = 18
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic HALT_EXEC_IN,
  input wire logic CLR_WDT_IN,
  input wire logic [PORT_W-1:0] PORT_A_IN,
  input wire logic [IRQ_W-1:0] IRQ_REQ_IN,
  input wire logic [IRQ_W-1:0] IRQ_EN_IN,
  input wire logic STACK_FULL_IN,
  input wire logic LOW_RC_OSC_IN,
  input wire logic HOSC_STABLE_IN,
  output logic HIGH_SPEED_CLOCK_RUN_OUT,
  output logic SLOW_CLOCK_RUN_OUT,
  output logic SYS_CLK_EN_OUT,
  output logic STATE_HOLD_OUT,
  output logic RESUME_NEXT_OUT,
  output logic IRQ_TAKE_OUT,
  output logic PC_SP_RESET_OUT,
  output logic WDT_RESET_OUT,
  output logic POWER_DOWN_FLAG_OUT,
  output logic WDT_EXPIRY_FLAG_OUT,
  output hiwc_pkg::hiwc_mode_t MODE_OUT,
  output logic IRQ_OUT
);
  import hiwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [PORT_W-1:0] pin_fall;
  logic low_rc_osc_tick;
  logic hosc_stable;

  hiwc_sync_edge #(.W(PORT_W)) u_pins (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .async_in(PORT_A_IN),
    .level_out(),
    .fall_out(pin_fall), // [R19]
    .rise_out()
  );

  hiwc_sync_edge #(.W(1)) u_low_rc_osc (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .async_in(LOW_RC_OSC_IN),
    .level_out(),
    .fall_out(),
    .rise_out(low_rc_osc_tick) // [R15] [R19]
  );

  hiwc_sync_edge #(.W(1)) u_hosc (
    .clk_in(SYS_CLK_IN),
    .reset_in(RESET_IN),
    .async_in(HOSC_STABLE_IN),
    .level_out(hosc_stable), // [R19]
    .fall_out(),
    .rise_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  hiwc_ctrl_t ctrl;
  logic [PORT_W-1:0] port_a_wake_enable;
  hiwc_evt_t irq_status;
  hiwc_evt_t irq_mask;
  logic [WDT_W-1:0] wdt_count;
  logic [WDT_W-1:0] wdt_limit;
  logic wdt_overflow;
  hiwc_state_t state;
  hiwc_mode_t mode;
  logic [IRQ_W-1:0] irq_armed;
  logic [IRQ_W-1:0] irq_wake_src;
  hiwc_evt_t wake_cause;
  hiwc_evt_t evt_set;
  logic [1:0] settle;
  logic halt_take;
  logic wake_pin;
  logic wake_irq;

  // Bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic [31:0] rd_data;

  assign halt_take = HALT_EXEC_IN && (state == ST_RUN);
  assign wake_pin = |(pin_fall & port_a_wake_enable); // [R7] [R10]
  // Only sources whose flag was clear at halt may wake the core
  assign wake_irq = |(IRQ_REQ_IN & irq_armed); // [R7] [R13]

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];

  always_comb begin
    rd_data = 32'h0;
    case (HADDR_IN[7:0])
      REG_CTRL: rd_data[4:0] = ctrl;
      REG_STATUS: begin
        rd_data[STAT_PDF] = POWER_DOWN_FLAG_OUT;
        rd_data[STAT_TO] = WDT_EXPIRY_FLAG_OUT;
        rd_data[STAT_STATE_LSB +: 2] = state;
        rd_data[STAT_MODE_LSB +: 2] = mode;
      end
      REG_WAKE_EN: rd_data[PORT_W-1:0] = port_a_wake_enable;
      REG_IRQ_STATUS: rd_data[EVT_W-1:0] = irq_status;
      REG_IRQ_MASK: rd_data[EVT_W-1:0] = irq_mask;
      REG_WDT_COUNT: rd_data[WDT_W-1:0] = wdt_count;
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      HRDATA_OUT <= 32'h0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      wr_pend <= addr_ok && HWRITE_IN;
      wr_addr <= HADDR_IN[7:0];
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      // Read data is sampled in the address phase to keep zero wait states
      if (addr_ok && !HWRITE_IN) begin
        HRDATA_OUT <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      ctrl <= '{wdt_period_sel: WDT_SEL_RESET,
                hi_osc_keep_on_halt: 1'b0,
                lo_osc_keep_on_halt: 1'b0};
      port_a_wake_enable <= '0;
      irq_mask <= IRQ_MASK_RESET;
    end else if (wr_pend) begin
      case (wr_addr)
        REG_CTRL: ctrl <= HWDATA_IN[4:0];
        REG_WAKE_EN: port_a_wake_enable <= HWDATA_IN[PORT_W-1:0];
        REG_IRQ_MASK: irq_mask <= HWDATA_IN[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event beats the clear
  always_comb begin
    evt_set = '0;
    evt_set.wake_pin = (state == ST_HALTED) && wake_pin;
    evt_set.wake_irq = (state == ST_HALTED) && wake_irq;
    evt_set.wake_wdt = (state == ST_HALTED) && wdt_overflow;
    evt_set.wdt_run_reset = (state != ST_HALTED) && wdt_overflow;
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      irq_status <= '0;
      IRQ_OUT <= 1'b0;
    end else begin
      if (wr_pend && wr_addr == REG_IRQ_STATUS) begin
        irq_status <= (irq_status & ~HWDATA_IN[EVT_W-1:0]) | evt_set;
      end else begin
        irq_status <= irq_status | evt_set;
      end
      IRQ_OUT <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: always enabled, counts slow RC ticks
  always_comb begin
    wdt_limit = '0;
    for (int i = 0; i < WDT_W; i++) begin
      wdt_limit[i] = (5'(i) < WDT_EXP[ctrl.wdt_period_sel]); // [R16] [R18]
    end
  end

  assign wdt_overflow = low_rc_osc_tick && ((wdt_count & wdt_limit) == wdt_limit);

  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      wdt_count <= '0;
    end else if (halt_take || CLR_WDT_IN || wdt_overflow) begin
      wdt_count <= '0; // [R6]
    end else if (low_rc_osc_tick) begin
      wdt_count <= wdt_count + 1'b1; // [R6] [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      POWER_DOWN_FLAG_OUT <= 1'b0;
      WDT_EXPIRY_FLAG_OUT <= 1'b0;
    end else begin
      // Halt wins over a clear-watchdog in the same cycle
      if (halt_take) begin
        POWER_DOWN_FLAG_OUT <= 1'b1; // [R5]
      end else if (CLR_WDT_IN) begin
        POWER_DOWN_FLAG_OUT <= 1'b0; // [R8]
      end
      if (wdt_overflow) begin
        WDT_EXPIRY_FLAG_OUT <= 1'b1; // [R9]
      end else if (halt_take) begin
        WDT_EXPIRY_FLAG_OUT <= 1'b0; // [R5]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-mode sequencer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      state <= ST_RUN;
      mode <= MODE_SLEEP;
      irq_armed <= '0;
      irq_wake_src <= '0;
      wake_cause <= '0;
      settle <= 2'h0;
    end else begin
      case (state)
        ST_RUN: begin
          if (halt_take) begin
            mode <= hiwc_mode_t'({ctrl.hi_osc_keep_on_halt,
                                  ctrl.lo_osc_keep_on_halt});
            irq_armed <= ~IRQ_REQ_IN; // [R13]
            wake_cause <= '0;
            state <= ST_HALTED;
          end
        end
        ST_HALTED: begin
          if (wdt_overflow || wake_irq || wake_pin) begin
            wake_cause.wake_wdt <= wdt_overflow;
            wake_cause.wake_irq <= wake_irq;
            wake_cause.wake_pin <= wake_pin;
            irq_wake_src <= IRQ_REQ_IN & irq_armed;
            settle <= 2'h0;
            state <= ST_STABILISE;
          end
        end
        ST_STABILISE: begin
          // Settle covers the stale stable level still in the synchroniser
          if (settle != SETTLE_CYCLES) begin
            settle <= settle + 2'h1;
          end else if (hosc_stable) begin
            state <= ST_RESUME; // [R14]
          end
        end
        ST_RESUME: state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating and core controls
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      HIGH_SPEED_CLOCK_RUN_OUT <= 1'b1;
      SLOW_CLOCK_RUN_OUT <= 1'b1;
      SYS_CLK_EN_OUT <= 1'b1;
      STATE_HOLD_OUT <= 1'b0;
      MODE_OUT <= MODE_SLEEP;
    end else begin
      if (halt_take) begin
        // Keep bits select which oscillators survive the halt
        HIGH_SPEED_CLOCK_RUN_OUT <= ctrl.hi_osc_keep_on_halt; // [R1] [R2] [R3]
        SLOW_CLOCK_RUN_OUT <= ctrl.lo_osc_keep_on_halt; // [R1] [R2] [R3] [R17]
        SYS_CLK_EN_OUT <= 1'b0; // [R17]
        STATE_HOLD_OUT <= 1'b1; // [R4]
        MODE_OUT <= hiwc_mode_t'({ctrl.hi_osc_keep_on_halt,
                                  ctrl.lo_osc_keep_on_halt});
      end else if (state == ST_HALTED && (wdt_overflow || wake_irq ||
                                          wake_pin)) begin
        // Restart both oscillators; the core stays gated until stable
        HIGH_SPEED_CLOCK_RUN_OUT <= 1'b1;
        SLOW_CLOCK_RUN_OUT <= 1'b1;
      end else if (state == ST_RESUME) begin
        SYS_CLK_EN_OUT <= 1'b1; // [R14]
        STATE_HOLD_OUT <= 1'b0;
      end
    end
  end

  // One-cycle directives to the core: resume causes as the clock returns, watchdog reset when not halted
  always_ff @(posedge SYS_CLK_IN) begin
    if (RESET_IN) begin
      RESUME_NEXT_OUT <= 1'b0;
      IRQ_TAKE_OUT <= 1'b0;
      PC_SP_RESET_OUT <= 1'b0;
      WDT_RESET_OUT <= 1'b0;
    end else begin
      RESUME_NEXT_OUT <= 1'b0;
      IRQ_TAKE_OUT <= 1'b0;
      PC_SP_RESET_OUT <= 1'b0;
      WDT_RESET_OUT <= (state != ST_HALTED) && wdt_overflow;
      if (state == ST_RESUME) begin
        if (wake_cause.wake_wdt) begin
          PC_SP_RESET_OUT <= 1'b1; // [R9]
        end else if (wake_cause.wake_irq &&
                     |(irq_wake_src & IRQ_EN_IN) && !STACK_FULL_IN) begin
          IRQ_TAKE_OUT <= 1'b1; // [R12]
        end else begin
          // Request stays set in the interrupt controller for later service
          RESUME_NEXT_OUT <= 1'b1; // [R10] [R11]
        end
      end
    end
  end

endmodule : hiwc_top

// ### test/hiwc_checker.sv
// Port-level checks of the halt and wake-up controller
`timescale 1ns/1ps
module hiwc_checker (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_IN,
  input wire logic HALT_EXEC_IN,
  input wire logic CLR_WDT_IN,
  input wire logic HOSC_STABLE_IN,
  input wire logic HIGH_SPEED_CLOCK_RUN_OUT,
  input wire logic SLOW_CLOCK_RUN_OUT,
  input wire logic SYS_CLK_EN_OUT,
  input wire logic STATE_HOLD_OUT,
  input wire logic RESUME_NEXT_OUT,
  input wire logic IRQ_TAKE_OUT,
  input wire logic PC_SP_RESET_OUT,
  input wire logic WDT_RESET_OUT,
  input wire logic POWER_DOWN_FLAG_OUT,
  input wire logic WDT_EXPIRY_FLAG_OUT,
  input wire hiwc_pkg::hiwc_mode_t MODE_OUT
);
  import hiwc_pkg::*;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  ////////////////////////////////////////////////////////////////////////////
  sequence halt_taken;
    HALT_EXEC_IN && SYS_CLK_EN_OUT;
  endsequence
  sequence core_parked;
    !SYS_CLK_EN_OUT && STATE_HOLD_OUT;
  endsequence
  // Fastest wake still needs the settle steps, so six parked cycles at least
  chk_halt_parks: assert property (
    halt_taken |=> core_parked [*6])
    else $error("core not parked after halt");
  // An overflow in the halt cycle itself wins and sets the expiry flag
  chk_halt_flags: assert property (
    halt_taken |=> POWER_DOWN_FLAG_OUT &&
    (!WDT_EXPIRY_FLAG_OUT || WDT_RESET_OUT))
    else $error("flags wrong after halt");
  chk_mode_clocks: assert property (
    $rose(STATE_HOLD_OUT) |-> HIGH_SPEED_CLOCK_RUN_OUT == MODE_OUT[1] &&
    SLOW_CLOCK_RUN_OUT == MODE_OUT[0])
    else $error("clock enables disagree with mode");
  chk_pdf_clear: assert property (
    $fell(POWER_DOWN_FLAG_OUT) |-> $past(CLR_WDT_IN))
    else $error("power-down flag cleared without cause");
  chk_one_cause: assert property (
    $rose(SYS_CLK_EN_OUT) |->
    $onehot({RESUME_NEXT_OUT, IRQ_TAKE_OUT, PC_SP_RESET_OUT}))
    else $error("resume without exactly one cause pulse");
  chk_stable_gate: assert property (
    !HOSC_STABLE_IN [*6] |-> !$rose(SYS_CLK_EN_OUT))
    else $error("resumed with oscillator unstable");
  chk_wdt_wake: assert property (
    PC_SP_RESET_OUT |-> WDT_EXPIRY_FLAG_OUT && POWER_DOWN_FLAG_OUT)
    else $error("watchdog wake flags wrong");
  chk_pulse_short: assert property (
    RESUME_NEXT_OUT || IRQ_TAKE_OUT |=> !RESUME_NEXT_OUT && !IRQ_TAKE_OUT)
    else $error("resume pulse too long");
  chk_run_wdt: assert property (
    WDT_RESET_OUT |-> ##[0:1] WDT_EXPIRY_FLAG_OUT)
    else $error("expiry flag missing after overflow");
endmodule : hiwc_checker

bind hiwc_top hiwc_checker i_chk (.SYS_CLK_IN, .RESET_IN, .HALT_EXEC_IN,
  .CLR_WDT_IN, .HOSC_STABLE_IN, .HIGH_SPEED_CLOCK_RUN_OUT,
  .SLOW_CLOCK_RUN_OUT, .SYS_CLK_EN_OUT, .STATE_HOLD_OUT, .RESUME_NEXT_OUT,
  .IRQ_TAKE_OUT, .PC_SP_RESET_OUT, .WDT_RESET_OUT, .POWER_DOWN_FLAG_OUT,
  .WDT_EXPIRY_FLAG_OUT, .MODE_OUT);

// ### test/hiwc_core_model.sv
// Core and interrupt controller stand-in issuing halt and requests
`timescale 1ns/1ps
module hiwc_core_model (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic halt_cmd_in,
  input wire logic clr_cmd_in,
  input wire logic [7:0] raise_in,
  input wire logic [7:0] enable_in,
  input wire logic run_in,
  input wire logic take_in,
  output logic halt_out,
  output logic clr_out,
  output logic [7:0] req_out
);
  // A parked core cannot execute, so nothing issues while gated
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      halt_out <= 1'b0;
      clr_out <= 1'b0;
    end else begin
      halt_out <= halt_cmd_in && run_in;
      clr_out <= clr_cmd_in && run_in;
    end
  end
  // Requests stay pending until an enabled response services them
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_out <= 8'h00;
    end else if (take_in) begin
      req_out <= (req_out & ~enable_in) | raise_in;
    end else begin
      req_out <= req_out | raise_in;
    end
  end
endmodule : hiwc_core_model

// ### test/test_halt_idle_wakeup_control.sv
// Random and corner-case bench for the halt, idle and wake-up controller
`timescale 1ns/1ps
module test_halt_idle_wakeup_control;
  import hiwc_pkg::*;
  logic clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hosc = 1'b1;
  logic lrc = 1'b0, lrc_on = 1'b0, go_halt = 1'b0, go_clr = 1'b0;
  logic st_full = 1'b0, halt, clr, hreadyout, tof, power_down_flag, irq;
  logic hclk_run, sclk_run, clk_en, hold, res_next, take, pcsp, wdt_rst;
  logic [1:0] htrans = 2'b00;
  logic [2:0] s, pin, p, lrc_div = 3'h0;
  logic [7:0] pa = 8'hff, raise = 8'h00, irq_en = 8'hff, req;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  hiwc_mode_t mode;
  int num_errors = 0, tests_run = 0, cyc = 0, t0;

  hiwc_top i_dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hreadyout),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(),
    .HALT_EXEC_IN(halt), .CLR_WDT_IN(clr), .PORT_A_IN(pa),
    .IRQ_REQ_IN(req), .IRQ_EN_IN(irq_en), .STACK_FULL_IN(st_full),
    .LOW_RC_OSC_IN(lrc), .HOSC_STABLE_IN(hosc),
    .HIGH_SPEED_CLOCK_RUN_OUT(hclk_run), .SLOW_CLOCK_RUN_OUT(sclk_run),
    .SYS_CLK_EN_OUT(clk_en), .STATE_HOLD_OUT(hold),
    .RESUME_NEXT_OUT(res_next), .IRQ_TAKE_OUT(take),
    .PC_SP_RESET_OUT(pcsp), .WDT_RESET_OUT(wdt_rst),
    .POWER_DOWN_FLAG_OUT(power_down_flag), .WDT_EXPIRY_FLAG_OUT(tof),
    .MODE_OUT(mode), .IRQ_OUT(irq));
  hiwc_core_model i_core (.clk_in(clk), .reset_in(rst),
    .halt_cmd_in(go_halt), .clr_cmd_in(go_clr), .raise_in(raise),
    .enable_in(irq_en), .run_in(clk_en), .take_in(take),
    .halt_out(halt), .clr_out(clr), .req_out(req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Slow oscillator stand-in: three cycles high, three low
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lrc_div <= (lrc_div == 3'h2) ? 3'h0 : lrc_div + 3'h1;
    if (lrc_on && lrc_div == 3'h2) lrc <= ~lrc;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic int ticks(input logic [2:0] sel);
    return (sel < 3'h4) ? (256 << (2 * sel)) : (1 << (11 + sel));
  endfunction : ticks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic halt_now();
    @(posedge clk);
    go_halt <= 1'b1;
    @(posedge clk);
    go_halt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : halt_now
  // Waits for the single cause pulse that ends a halt
  task automatic wait_wake(output logic [2:0] cause);
    cause = 3'h0;
    for (int n = 0; n < 9000 && cause == 3'h0; n++) begin
      @(posedge clk);
      cause = {pcsp, take, res_next};
    end
  endtask : wait_wake
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'ha95b));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ahb(0, REG_CTRL, 0);
    chk(q, {27'h0, WDT_SEL_RESET, 2'b00});
    ahb(0, 8'h18, 0);
    chk(q, 0);
    for (int m = 0; m < 4; m++) begin
      s = 3'($urandom_range(7));
      pin = 3'($urandom_range(7));
      ahb(1, REG_CTRL, {27'h0, s, m[1:0]});
      ahb(0, REG_CTRL, 0);
      chk(q, {27'h0, s, m[1:0]});
      ahb(1, REG_WAKE_EN, 32'h1 << pin);
      halt_now();
      chk({hclk_run, sclk_run, mode, clk_en, hold},
          {m[1:0], m[1:0], 2'b01});
      chk({power_down_flag, tof}, 2'b10);
      // A pin without its wake enable must leave the core parked
      pa <= ~(8'h1 << (pin ^ 3'h1));
      repeat (10) @(posedge clk);
      chk(hold, 1);
      pa <= 8'h00;
      wait_wake(p);
      chk({p, clk_en, hold, power_down_flag}, 6'b001101);
      pa <= 8'hff;
    end
    @(posedge clk);
    go_clr <= 1'b1;
    @(posedge clk);
    go_clr <= 1'b0;
    repeat (3) @(posedge clk);
    chk(power_down_flag, 0);
    for (int k = 0; k < 3; k++) begin
      irq_en <= (k == 1) ? 8'h00 : 8'hff;
      st_full <= (k == 2);
      halt_now();
      raise <= 8'h1 << k;
      @(posedge clk);
      raise <= 8'h00;
      wait_wake(p);
      chk(p, (k == 0) ? 3'b010 : 3'b001);
    end
    st_full <= 1'b0;
    raise <= 8'h08;
    @(posedge clk);
    raise <= 8'h00;
    hosc <= 1'b0;
    halt_now();
    repeat (30) @(posedge clk);
    chk(hold, 1);
    pa <= 8'h00;
    repeat (40) @(posedge clk);
    chk({hold, clk_en}, 2'b10);
    hosc <= 1'b1;
    wait_wake(p);
    chk(p, 3'b001);
    pa <= 8'hff;
    // Overflow while running, with its status bit masked
    ahb(1, REG_CTRL, 0);
    lrc_on <= 1'b1;
    for (int n = 0; n < 3000 && wdt_rst !== 1'b1; n++) @(posedge clk);
    chk(wdt_rst, 1);
    repeat (2) @(posedge clk);
    chk({tof, irq}, 2'b10);
    ahb(1, REG_IRQ_MASK, 32'hc);
    ahb(0, REG_IRQ_STATUS, 0);
    // Pin and interrupt wakes of the earlier halts are still sticky
    chk({q[7:0], irq}, {8'hb, 1'b1});
    ahb(1, REG_IRQ_STATUS, 32'hf);
    for (int k = 0; k < 2; k++) begin
      ahb(1, REG_CTRL, {27'h0, k[2:0], 2'b11});
      halt_now();
      t0 = cyc;
      wait_wake(p);
      chk(p, 3'b100);
      chk(cyc - t0 > 6 * ticks(k) - 12 && cyc - t0 < 6 * ticks(k) + 30, 1);
      ahb(0, REG_IRQ_STATUS, 0);
      chk({q[7:0], irq}, {8'h4, 1'b1});
      ahb(1, REG_IRQ_STATUS, 32'h4);
      ahb(0, REG_STATUS, 0);
      chk({q[5:0], irq}, 7'b1100110);
    end
    tally_and_finish();
  end
endmodule : test_halt_idle_wakeup_control
